// ### hdl/port_pin_assignment_regs.vh
`ifndef PORT_PIN_ASSIGNMENT_REGS_VH
`define PORT_PIN_ASSIGNMENT_REGS_VH
// =====================================================================
// Register pages and addresses
// =====================================================================
`define CFG_PAGE        4'hf
`define ADR_P2_DATA     8'ha0
`define ADR_P1_DRIVE    8'ha5
`define ADR_P0_DATA     8'hb0
`define ADR_P1_DATA     8'hb1
`define ADR_SKIP0       8'hb2
`define ADR_SKIP1       8'hb3
`define ADR_SKIP2       8'hb4
`define ADR_INMODE0     8'hb5
`define ADR_INMODE1     8'hb6
`define ADR_INMODE2     8'hb7
`define ADR_OUTMODE0    8'hb8
`define ADR_OUTMODE1    8'hb9
`define ADR_OUTMODE2    8'hba
`define ADR_XBAR_A      8'hbb
`define ADR_XBAR_B      8'hbc
`define ADR_XBAR_C      8'hbd
`define ADR_CONV_SEL    8'hbe
`define ADR_CMP_SEL     8'hbf
`define ADR_EXTINT_CFG  8'hc0
`define ADR_P0_MASK     8'hc1
`define ADR_P0_MATCH    8'hc2
`define ADR_P1_MASK     8'hc3
`define ADR_P1_MATCH    8'hc4
`define ADR_EVT_STATUS  8'hc5
`define ADR_EVT_MASK    8'hc6
// =====================================================================
// Bit address range of the port 2 data register
// =====================================================================
`define P2_BIT_BASE     5'h14
// =====================================================================
// Field positions
// =====================================================================
`define XC_XBAR_EN      6
`define XA_UART_EN      0
`define XA_SECOND_SERIAL_PERIPHERAL_EN      1
`define EXT_POL         3
`define EV_INT0         0
`define EV_INT1         1
`define EV_MATCH        2
// =====================================================================
// Reset values
// =====================================================================
`define RST_LATCH       8'hff
`define RST_ZERO        8'h00
`define RST_INMODE      8'hff
`define RST_SEL         8'h1f
// =====================================================================
// Pin counts
// =====================================================================
`define NPIN            23
`define NSLOT           12
`define NFIX            6
`endif

// ### hdl/port_pin_assignment.v
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`include "port_pin_assignment_regs.vh"

module port_pin_assignment #(
    parameter LARGE_PKG = 1
) (
    input  wire                clock,
    input  wire                rst_b,
    input  wire [3:0]          sfr_page,
    input  wire [7:0]          addr,
    input  wire [7:0]          wdata,
    input  wire                wr,
    input  wire                rd,
    output reg  [7:0]          rdata,
    input  wire                bit_wr,
    input  wire [7:0]          bit_addr,
    input  wire                bit_wdata,
    input  wire [`NPIN-1:0]    pin_in,
    output reg  [`NPIN-1:0]    pin_out,
    output reg  [`NPIN-1:0]    pin_oe,
    output wire [`NPIN-1:0]    pin_pullup,
    output wire [7:0]          p1_drive_high,
    input  wire [`NSLOT-1:0]   xbar_out,
    input  wire [`NSLOT-1:0]   xbar_oe,
    output reg  [`NSLOT-1:0]   xbar_in,
    input  wire [`NFIX-1:0]    fixed_out,
    input  wire [`NFIX-1:0]    fixed_oe,
    output reg  [`NFIX-1:0]    fixed_in,
    output wire [4:0]          conv_pin,
    output wire                conv_pin_ok,
    output wire [4:0]          cmp_pin,
    output wire                cmp_pin_ok,
    output wire                irq,
    output wire                wake
);

    // =================================================================
    // Pin availability and fixed pin map
    // =================================================================
    // Fixed order: UART tx, rx on P0.4, P0.5; second SPI on P1.0..P1.3.
    localparam [`NPIN-1:0] SMALL_AVAIL = 23'h007fff;
    localparam [`NPIN-1:0] AVAIL       = LARGE_PKG ? {`NPIN{1'b1}} : SMALL_AVAIL;
    localparam [4*5-1:0]   FIX_PIN_HI  = {5'd11, 5'd10, 5'd9, 5'd8};

    // Port 0 and 1 latches live on the configuration page only; the port 2
    // latch is the one register that every page reaches.
    // Skip, mode and select registers reset so that every pin comes up as a
    // released digital input with its pull-up on.
    reg  [7:0]       p0_lat_r, p1_lat_r, p2_lat_r;
    reg  [7:0]       skip0_r, skip1_r, skip2_r;
    reg  [7:0]       inm0_r, inm1_r, inm2_r;
    reg  [7:0]       outm0_r, outm1_r, outm2_r;
    reg  [7:0]       xa_r, xb_r, xc_r;
    reg  [7:0]       conv_r, cmp_r, ext_r;
    reg  [7:0]       p0_msk_r, p0_mat_r, p1_msk_r, p1_mat_r;
    reg  [7:0]       p1_drv_r;
    reg  [2:0]       ev_st_r, ev_msk_r;
    reg  [`NPIN-1:0] meta_r, sync_r;

    wire [`NPIN-1:0] skip    = {skip2_r[6:0], skip1_r, skip0_r};
    wire [`NPIN-1:0] dig     = {inm2_r[6:0], inm1_r, inm0_r};
    wire [`NPIN-1:0] pushp   = {outm2_r[6:0], outm1_r, outm0_r};
    wire [`NPIN-1:0] latch   = {p2_lat_r[6:0], p1_lat_r, p0_lat_r};
    // Analog and missing pins read zero, so capture never sees an edge.
    wire [`NPIN-1:0] pin_dig = sync_r & dig & AVAIL;

    reg  [`NPIN-1:0] fix_use;
    reg  [`NFIX-1:0] fix_en;
    integer          f;

    always @* begin
        fix_en = {{4{xa_r[`XA_SECOND_SERIAL_PERIPHERAL_EN]}}, {2{xa_r[`XA_UART_EN]}}};
        // Fixed pins only leave the free list while the crossbar is on, so
        // turning it off hands them straight back to their latches.
        fix_use = {`NPIN{1'b0}};
        if (xc_r[`XC_XBAR_EN]) begin
            fix_use[4] = fix_en[0];
            fix_use[5] = fix_en[1];
            for (f = 0; f < 4; f = f + 1) begin
                fix_use[FIX_PIN_HI[f*5 +: 5]] = fix_en[f+2];
            end
        end
    end

    // =================================================================
    // Crossbar ranking
    // =================================================================
    // Slot k takes the k-th free pin counted among enabled slots only.
    // A skipped pin never counts as free, so no crossbar slot can land on it.
    // Both rankings are plain prefix counts; the compare below costs one
    // 5-bit comparator per pin and slot pair, traded for a short, flat path.
    wire [`NPIN-1:0]  free    = ~skip & ~fix_use & AVAIL;
    wire [`NSLOT-1:0] slot_en = {xb_r[5:0], xa_r[7:2]};

    reg  [`NPIN*5-1:0]  pin_rank;
    reg  [`NSLOT*5-1:0] slot_rank;
    reg  [4:0]          pcnt, scnt;
    integer             p, s;

    always @* begin
        pcnt = 5'd0;
        scnt = 5'd0;
        pin_rank = {`NPIN*5{1'b0}};
        slot_rank = {`NSLOT*5{1'b0}};
        for (p = 0; p < `NPIN; p = p + 1) begin
            pin_rank[p*5 +: 5] = pcnt;
            if (free[p]) begin
                pcnt = pcnt + 5'd1;
            end
        end
        for (s = 0; s < `NSLOT; s = s + 1) begin
            slot_rank[s*5 +: 5] = scnt;
            if (slot_en[s]) begin
                scnt = scnt + 5'd1;
            end
        end
    end

    // =================================================================
    // Per-pin source selection and output mode
    // =================================================================
    reg  [`NPIN-1:0] src_val, src_oe, drv_out, drv_oe;
    reg  [`NSLOT-1:0] slot_in;
    reg  [`NFIX-1:0]  fix_in;
    integer           q, k;
    // A pin with no peripheral behind it falls back to its port latch, so
    // an idle crossbar slot leaves the pad exactly as GPIO would.

    always @* begin
        src_val = latch;
        src_oe = {`NPIN{1'b1}};
        slot_in = {`NSLOT{1'b0}};
        fix_in = {`NFIX{1'b0}};
        for (q = 0; q < `NPIN; q = q + 1) begin
            for (k = 0; k < `NSLOT; k = k + 1) begin
                if (xc_r[`XC_XBAR_EN] && free[q] && slot_en[k] &&
                    slot_rank[k*5 +: 5] == pin_rank[q*5 +: 5]) begin
                    src_val[q] = xbar_out[k];
                    src_oe[q] = xbar_oe[k];
                    slot_in[k] = pin_dig[q];
                end
            end
        end
        if (fix_use[4]) begin
            src_val[4] = fixed_out[0];
            src_oe[4] = fixed_oe[0];
        end
        if (fix_use[5]) begin
            src_val[5] = fixed_out[1];
            src_oe[5] = fixed_oe[1];
        end
        fix_in[0] = pin_dig[4] & fix_use[4];
        fix_in[1] = pin_dig[5] & fix_use[5];
        for (k = 0; k < 4; k = k + 1) begin
            if (fix_use[FIX_PIN_HI[k*5 +: 5]]) begin
                src_val[FIX_PIN_HI[k*5 +: 5]] = fixed_out[k+2];
                src_oe[FIX_PIN_HI[k*5 +: 5]] = fixed_oe[k+2];
                fix_in[k+2] = pin_dig[FIX_PIN_HI[k*5 +: 5]];
            end
        end
        // Open-drain only ever pulls low; push-pull drives both rails.
        drv_out = src_val & pushp;
        drv_oe = src_oe & (pushp | ~src_val) & AVAIL;
    end

    // Analog pins lose the pull-up; so does any pin driven low.
    assign pin_pullup = dig & AVAIL & ~(drv_oe & ~drv_out) &
                        {`NPIN{~xc_r[7]}};
    assign p1_drive_high = p1_drv_r & {LARGE_PKG != 0, 7'h7f};

    // =================================================================
    // Analog input selection
    // =================================================================
    // The choice only counts as valid when the chosen pin is reserved.
    assign conv_pin = conv_r[4:0];
    assign cmp_pin = cmp_r[4:0];
    assign conv_pin_ok = conv_r[4:0] < 5'd23 && skip[conv_r[4:0]] &&
                         AVAIL[conv_r[4:0]];
    assign cmp_pin_ok = cmp_r[4:0] < 5'd23 && skip[cmp_r[4:0]] &&
                        AVAIL[cmp_r[4:0]];

    // =================================================================
    // Event capture
    // =================================================================
    reg  [1:0] ext_lvl_r;
    reg        mis_r;
    // Edges are taken from the synchronised level, so a pulse is seen once it spans
    // one rising clock edge. Rewriting the pin or polarity select can itself make
    // an edge; software clears the status after changing the configuration.

    wire       ext0 = pin_dig[ext_r[2:0]] ^ ~ext_r[`EXT_POL];
    wire       ext1 = pin_dig[{1'b0, ext_r[6:4]}] ^ ~ext_r[`EXT_POL+4];
    wire [7:0] p1_avail_msk = LARGE_PKG ? 8'hff : 8'h3f;
    // Mismatch works on every digital port 0 and port 1 pin but P1.6 of the small package, skipped or crossbar owned.
    wire       mis = |((pin_dig[7:0] ^ p0_mat_r) & p0_msk_r) |
                     |((pin_dig[15:8] ^ p1_mat_r) & p1_msk_r & p1_avail_msk);
    wire [2:0] ev_set = {mis & ~mis_r, ext1 & ~ext_lvl_r[1],
                         ext0 & ~ext_lvl_r[0]};

    assign irq = |(ev_st_r & ev_msk_r);
    assign wake = irq;

    // =================================================================
    // Register bus
    // =================================================================
    wire       cfg_pg = sfr_page == `CFG_PAGE;
    wire [7:0] p2_pins = {1'b0, pin_dig[22:16]};
    wire       p2_bit = bit_wr && bit_addr[7:3] == `P2_BIT_BASE;
    reg  [7:0] rd_nxt;

    always @* begin
        rd_nxt = 8'h00;
        if (addr == `ADR_P2_DATA) begin
            rd_nxt = p2_pins;
        end else if (cfg_pg) begin
            case (addr)
                `ADR_P1_DRIVE:   rd_nxt = p1_drv_r;
                `ADR_P0_DATA:    rd_nxt = pin_dig[7:0];
                `ADR_P1_DATA:    rd_nxt = pin_dig[15:8];
                `ADR_SKIP0:      rd_nxt = skip0_r;
                `ADR_SKIP1:      rd_nxt = skip1_r;
                `ADR_SKIP2:      rd_nxt = skip2_r;
                `ADR_INMODE0:    rd_nxt = inm0_r;
                `ADR_INMODE1:    rd_nxt = inm1_r;
                `ADR_INMODE2:    rd_nxt = inm2_r;
                `ADR_OUTMODE0:   rd_nxt = outm0_r;
                `ADR_OUTMODE1:   rd_nxt = outm1_r;
                `ADR_OUTMODE2:   rd_nxt = outm2_r;
                `ADR_XBAR_A:     rd_nxt = xa_r;
                `ADR_XBAR_B:     rd_nxt = xb_r;
                `ADR_XBAR_C:     rd_nxt = xc_r;
                `ADR_CONV_SEL:   rd_nxt = conv_r;
                `ADR_CMP_SEL:    rd_nxt = cmp_r;
                `ADR_EXTINT_CFG: rd_nxt = ext_r;
                `ADR_P0_MASK:    rd_nxt = p0_msk_r;
                `ADR_P0_MATCH:   rd_nxt = p0_mat_r;
                `ADR_P1_MASK:    rd_nxt = p1_msk_r;
                `ADR_P1_MATCH:   rd_nxt = p1_mat_r;
                `ADR_EVT_STATUS: rd_nxt = {5'h00, ev_st_r};
                `ADR_EVT_MASK:   rd_nxt = {5'h00, ev_msk_r};
                default:         rd_nxt = 8'h00;
            endcase
        end
    end

    wire cw = wr && cfg_pg;
    // Status bits are only written through the clear path below, never through
    // the plain register case, so a write of zero leaves them alone.

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
            p0_lat_r <= `RST_LATCH;
            p1_lat_r <= `RST_LATCH;
            p2_lat_r <= `RST_LATCH;
            skip0_r <= `RST_ZERO;
            skip1_r <= `RST_ZERO;
            skip2_r <= `RST_ZERO;
            inm0_r <= `RST_INMODE;
            inm1_r <= `RST_INMODE;
            inm2_r <= `RST_INMODE;
            outm0_r <= `RST_ZERO;
            outm1_r <= `RST_ZERO;
            outm2_r <= `RST_ZERO;
            xa_r <= `RST_ZERO;
            xb_r <= `RST_ZERO;
            xc_r <= `RST_ZERO;
            conv_r <= `RST_SEL;
            cmp_r <= `RST_SEL;
            ext_r <= `RST_ZERO;
            p0_msk_r <= `RST_ZERO;
            p0_mat_r <= `RST_LATCH;
            p1_msk_r <= `RST_ZERO;
            p1_mat_r <= `RST_LATCH;
            p1_drv_r <= `RST_ZERO;
            ev_msk_r <= 3'h0;
            ev_st_r <= 3'h0;
        end else begin
            if (rd) begin
                rdata <= rd_nxt;
            end
            if (wr && addr == `ADR_P2_DATA) begin
                p2_lat_r <= wdata;
            end else if (p2_bit) begin
                p2_lat_r[bit_addr[2:0]] <= bit_wdata;
            end
            if (cw) begin
                case (addr)
                    `ADR_P1_DRIVE:   p1_drv_r <= wdata;
                    `ADR_P0_DATA:    p0_lat_r <= wdata;
                    `ADR_P1_DATA:    p1_lat_r <= wdata;
                    `ADR_SKIP0:      skip0_r <= wdata;
                    `ADR_SKIP1:      skip1_r <= wdata;
                    `ADR_SKIP2:      skip2_r <= wdata;
                    `ADR_INMODE0:    inm0_r <= wdata;
                    `ADR_INMODE1:    inm1_r <= wdata;
                    `ADR_INMODE2:    inm2_r <= wdata;
                    `ADR_OUTMODE0:   outm0_r <= wdata;
                    `ADR_OUTMODE1:   outm1_r <= wdata;
                    `ADR_OUTMODE2:   outm2_r <= wdata;
                    `ADR_XBAR_A:     xa_r <= wdata;
                    `ADR_XBAR_B:     xb_r <= wdata;
                    `ADR_XBAR_C:     xc_r <= wdata;
                    `ADR_CONV_SEL:   conv_r <= wdata;
                    `ADR_CMP_SEL:    cmp_r <= wdata;
                    `ADR_EXTINT_CFG: ext_r <= wdata;
                    `ADR_P0_MASK:    p0_msk_r <= wdata;
                    `ADR_P0_MATCH:   p0_mat_r <= wdata;
                    `ADR_P1_MASK:    p1_msk_r <= wdata;
                    `ADR_P1_MATCH:   p1_mat_r <= wdata;
                    `ADR_EVT_MASK:   ev_msk_r <= wdata[2:0];
                    default:         ;
                endcase
            end
            // A new event in the clearing cycle stays set.
            if (cw && addr == `ADR_EVT_STATUS) begin
                ev_st_r <= (ev_st_r & ~wdata[2:0]) | ev_set;
            end else begin
                ev_st_r <= ev_st_r | ev_set;
            end
        end
    end

    // =================================================================
    // Pin synchroniser, edge history and registered pad drive
    // =================================================================
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            // The synchroniser clears low, which the active-low reset polarity reads as
            // both external interrupts asserted; the edge history starts high to mask it.
            meta_r <= {`NPIN{1'b0}};
            sync_r <= {`NPIN{1'b0}};
            ext_lvl_r <= 2'b11;
            mis_r <= 1'b0;
            pin_out <= {`NPIN{1'b0}};
            pin_oe <= {`NPIN{1'b0}};
            xbar_in <= {`NSLOT{1'b0}};
            fixed_in <= {`NFIX{1'b0}};
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            ext_lvl_r <= {ext1, ext0};
            mis_r <= mis;
            pin_out <= drv_out;
            pin_oe <= drv_oe;
            xbar_in <= slot_in;
            fixed_in <= fix_in;
        end
    end

endmodule // port_pin_assignment

// ### test/port_pin_assignment_sva.sv
`timescale 1ns/100ps
// ====================
// Port pin assignment checker
// ====================
module port_pin_assignment_chk #(
    parameter LARGE_PKG = 1
) (
    input wire        clock,
    input wire        rst_b,
    input wire [3:0]  sfr_page,
    input wire [7:0]  addr,
    input wire [7:0]  wdata,
    input wire        wr,
    input wire        rd,
    input wire [7:0]  rdata,
    input wire        bit_wr,
    input wire [7:0]  bit_addr,
    input wire        bit_wdata,
    input wire [22:0] pin_oe,
    input wire [7:0]  p1_drive_high,
    input wire [4:0]  conv_pin,
    input wire        conv_pin_ok,
    input wire        irq,
    input wire        wake
);
    // The small package loses P1.7 and all of port 2, so indices from 15 up vanish.
    localparam [7:0] DMASK = (LARGE_PKG != 0) ? 8'hff : 8'h7f;
    localparam [4:0] PMAX  = (LARGE_PKG != 0) ? 5'h17 : 5'h0f;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    chk_wake_irq: assert property (wake == irq)
        else $error("wake and irq differ");
    chk_unmapped_read: assert property (
        rd && sfr_page == 4'hf && addr == 8'h00 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_drive_write: assert property (
        wr && sfr_page == 4'hf && addr == 8'ha5 |=> p1_drive_high == ($past(wdata) & DMASK))
        else $error("drive strength not taken");
    chk_drive_page: assert property (
        wr && sfr_page != 4'hf && addr == 8'ha5 |=> $stable(p1_drive_high))
        else $error("drive strength written off page");
    chk_p2_latch_oe: assert property (
        (LARGE_PKG != 0) && wr && addr == 8'ha0 |=> ##1 pin_oe[22:16] == ~$past(wdata[6:0], 2))
        else $error("port 2 latch not at pins");
    chk_p2_bit_oe: assert property (
        bit_wr && bit_addr == 8'ha2 |=> ##1 pin_oe[18] == !$past(bit_wdata, 2))
        else $error("port 2 bit write not at pin");
    chk_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    chk_rst_quiet: assert property (
        $rose(rst_b) |-> !irq && p1_drive_high == 8'h00)
        else $error("state after reset wrong");
    chk_conv_range: assert property (conv_pin_ok |-> conv_pin < PMAX)
        else $error("converter pin out of range");
endmodule // port_pin_assignment_chk
bind port_pin_assignment port_pin_assignment_chk #(.LARGE_PKG(LARGE_PKG)) i_chk (
    .clock(clock), .rst_b(rst_b), .sfr_page(sfr_page), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .bit_wr(bit_wr), .bit_addr(bit_addr),
    .bit_wdata(bit_wdata), .pin_oe(pin_oe), .p1_drive_high(p1_drive_high),
    .conv_pin(conv_pin), .conv_pin_ok(conv_pin_ok), .irq(irq), .wake(wake)
);

// ### test/pin_world.sv
`timescale 1ns/100ps
// ====================
// Pads and the circuitry on them
// ====================
module pin_world (
    input  wire        clock,
    input  wire [22:0] pin_out,
    input  wire [22:0] pin_oe,
    input  wire [22:0] pin_pullup,
    input  wire [22:0] ext_en,
    input  wire [22:0] ext_val,
    output reg  [22:0] pin_in
);
    // A pad nobody drives or pulls toggles every cycle, so a float never looks stable.
    reg     [22:0] float_r = 23'h2aaaaa;
    integer        k;
    always @(posedge clock) float_r <= ~float_r;
    always @* begin
        for (k = 0; k < 23; k = k + 1) begin
            if (ext_en[k])
                pin_in[k] = ext_val[k];
            else if (pin_oe[k])
                pin_in[k] = pin_out[k];
            else if (pin_pullup[k])
                pin_in[k] = 1'b1;
            else
                pin_in[k] = float_r[k];
        end
    end
endmodule // pin_world

// ### test/tb_port_pin_assignment.sv
`timescale 1ns/100ps
module tb_port_pin_assignment;
    reg         clock      = 1'b0;
    reg         rst_b      = 1'b0;
    reg  [3:0]  sfr_page   = 4'h0;
    reg  [7:0]  addr       = 8'h00;
    reg  [7:0]  wdata      = 8'h00;
    reg         wr         = 1'b0;
    reg         rd         = 1'b0;
    reg         bit_wr     = 1'b0;
    reg  [7:0]  bit_addr   = 8'h00;
    reg         bit_wdata  = 1'b0;
    reg  [11:0] xbar_out   = 12'h000;
    reg  [11:0] xbar_oe    = 12'h000;
    reg  [5:0]  fixed_out  = 6'h00;
    reg  [5:0]  fixed_oe   = 6'h00;
    reg  [22:0] ext_en     = 23'h000000;
    reg  [22:0] ext_val    = 23'h000000;
    reg         rd_d       = 1'b0;
    reg  [7:0]  v;
    reg  [7:0]  e;
    reg  [7:0]  exp_q[$];
    integer     n_mismatch = 0;
    integer     n_tests    = 0;
    integer     seed       = 32'hfae4beaf;
    integer     i;
    integer     k;
    wire [7:0]  rdata;
    wire [7:0]  p1_drive_high;
    wire [22:0] pin_in;
    wire [22:0] pin_out;
    wire [22:0] pin_oe;
    wire [22:0] pin_pullup;
    wire [5:0]  fixed_in;
    wire [4:0]  conv_pin;
    wire        conv_pin_ok;
    wire        irq;
    wire        wake;

    always #5 clock = ~clock;

    port_pin_assignment #(.LARGE_PKG(1)) i_port_pin_assignment (
        .clock(clock), .rst_b(rst_b), .sfr_page(sfr_page), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .bit_wr(bit_wr),
        .bit_addr(bit_addr), .bit_wdata(bit_wdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .p1_drive_high(p1_drive_high), .xbar_out(xbar_out), .xbar_oe(xbar_oe),
        .xbar_in(), .fixed_out(fixed_out), .fixed_oe(fixed_oe),
        .fixed_in(fixed_in), .conv_pin(conv_pin), .conv_pin_ok(conv_pin_ok),
        .cmp_pin(), .cmp_pin_ok(), .irq(irq), .wake(wake)
    );
    pin_world i_pin_world (
        .clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
    );

    // ====================
    // Checking and closing
    // ====================
    task check(input [63:0] what, input [22:0] seen, input [22:0] expv);
        begin
            n_tests = n_tests + 1;
            if (seen !== expv) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, expv, seen);
            end
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Read data change on the edge after the strobe and hold until the next read, so they are taken mid-cycle.
    always @(posedge clock) rd_d <= rd;
    always @(negedge clock) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            check("rdata", rdata, e);
        end
    end
    initial begin
        #300000;
        n_mismatch = n_mismatch + 1;
        test_done;
    end

    // ====================
    // Bus and pad tasks
    // ====================
    // Strobes are set once before the edge and not lowered after it inside bus, so back-to-back calls never assign twice.
    task bus(input w, input [3:0] pg, input [7:0] a, input [7:0] d);
        begin
            wr <= w;
            rd <= !w;
            sfr_page <= pg;
            addr <= a;
            wdata <= d;
            @(posedge clock);
        end
    endtask
    task rdr(input [3:0] pg, input [7:0] a, input [7:0] x);
        begin
            exp_q.push_back(x);
            bus(1'b0, pg, a, 8'h00);
        end
    endtask
    task idle(input integer n);
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            bit_wr <= 1'b0;
            repeat (n) @(posedge clock);
        end
    endtask
    task bwr(input [7:0] a, input b);
        begin
            wr <= 1'b0;
            bit_wr <= 1'b1;
            bit_addr <= a;
            bit_wdata <= b;
            @(posedge clock);
        end
    endtask
    // A read in flight must be checked before reset wipes its data, so
    // a mid-run reset lets one edge pass with the strobes low first.
    task do_reset;
        begin
            wr <= 1'b0;
            rd <= 1'b0;
            bit_wr <= 1'b0;
            if (rst_b)
                @(posedge clock);
            rst_b <= 1'b0;
            repeat (4) @(posedge clock);
            rst_b <= 1'b1;
            idle(3);
        end
    endtask
    task pulse(input integer p);
        begin
            ext_en[p] <= 1'b1;
            ext_val[p] <= 1'b0;
            idle(3);
            ext_en[p] <= 1'b0;
        end
    endtask
    task wait_irq;
        begin
            for (i = 0; i < 20 && irq !== 1'b1; i = i + 1)
                @(negedge clock);
            check("irq", irq, 1'b1);
            if (irq !== 1'b1)
                test_done;
            @(posedge clock);
        end
    endtask
    task event_chk(input integer p, input [7:0] s);
        begin
            pulse(p);
            wait_irq;
            rdr(4'hf, 8'hc5, s);
            bus(1'b1, 4'hf, 8'hc5, s);
            idle(1);
            check("irqclr", irq, 1'b0);
        end
    endtask

    // ====================
    // Scenarios
    // ====================
    initial begin
        do_reset;
        rdr(4'hf, 8'ha5, 8'h00);
        rdr(4'h2, 8'ha0, 8'h7f);
        for (k = 0; k < 4; k = k + 1) begin
            v = $random(seed);
            bus(1'b1, 4'hf, 8'ha5, v);
            rdr(4'hf, 8'ha5, v);
            check("drive", p1_drive_high, v);
        end
        bus(1'b1, 4'h0, 8'ha5, ~v);
        rdr(4'hf, 8'ha5, v);
        rdr(4'h1, 8'ha5, 8'h00);
        rdr(4'hf, 8'h00, 8'h00);
        $display("test drive done");
        v = $random(seed);
        bus(1'b1, 4'h5, 8'ha0, v);
        idle(4);
        rdr(4'h0, 8'ha0, v & 8'h7f);
        bus(1'b1, 4'h9, 8'ha0, 8'hff);
        ext_en[17] <= 1'b1;
        ext_val[17] <= 1'b0;
        bwr(8'ha2, 1'b0);
        idle(4);
        rdr(4'h0, 8'ha0, 8'h79);
        ext_en[17] <= 1'b0;
        $display("test port2 done");
        bus(1'b1, 4'hf, 8'hb9, 8'hff);
        bus(1'b1, 4'hf, 8'hb1, 8'h0f);
        bus(1'b1, 4'hf, 8'hb2, 8'h01);
        bus(1'b1, 4'hf, 8'hb5, 8'hfe);
        bus(1'b1, 4'hf, 8'hbe, 8'h00);
        idle(3);
        check("p1oe", pin_oe[15:8], 8'hff);
        check("p1out", pin_out[15:8], 8'h0f);
        check("pullup", pin_pullup[0], 1'b0);
        check("conv", {conv_pin_ok, conv_pin}, 6'h20);
        rdr(4'hf, 8'hb0, 8'hfe);
        rdr(4'hf, 8'hb1, 8'h0f);
        $display("test modes done");
        do_reset;
        bus(1'b1, 4'hf, 8'hc0, 8'heb);
        bus(1'b1, 4'hf, 8'hb2, 8'h08);
        bus(1'b1, 4'hf, 8'hc3, 8'h40);
        bus(1'b1, 4'hf, 8'hc6, 8'h07);
        idle(4);
        // Selecting the pins and polarities may itself log an edge; clear it.
        bus(1'b1, 4'hf, 8'hc5, 8'h07);
        rdr(4'hf, 8'hc5, 8'h00);
        for (k = 0; k < 3; k = k + 1)
            event_chk((k == 0) ? 3 : ((k == 1) ? 6 : 14), 8'h01 << k);
        bus(1'b1, 4'hf, 8'hc6, 8'h04);
        pulse(3);
        idle(6);
        check("masked", irq, 1'b0);
        bus(1'b1, 4'hf, 8'hc6, 8'h07);
        idle(1);
        check("unmask", irq, 1'b1);
        bus(1'b1, 4'hf, 8'hc5, 8'h01);
        bus(1'b1, 4'hf, 8'hb5, 8'hf7);
        idle(3);
        pulse(3);
        idle(6);
        rdr(4'hf, 8'hc5, 8'h00);
        $display("test events done");
        bus(1'b1, 4'hf, 8'hb2, 8'h01);
        bus(1'b1, 4'hf, 8'hbb, 8'h05);
        bus(1'b1, 4'hf, 8'hbd, 8'h40);
        xbar_oe[0] <= 1'b1;
        fixed_oe[0] <= 1'b1;
        idle(3);
        check("xbar", pin_oe[5:0], 6'h12);
        bus(1'b1, 4'hf, 8'hb2, 8'h03);
        idle(3);
        check("skip", pin_oe[5:0], 6'h14);
        ext_en[5] <= 1'b1;
        ext_val[5] <= 1'b0;
        idle(5);
        check("uartrx", fixed_in[1], 1'b0);
        $display("test crossbar done");
        test_done;
    end
endmodule // tb_port_pin_assignment
